// ---- design/scs_spi_clock_stop.sv ----
`timescale 1ns/1ps
// How it works
// - Slave needs rate clock at half core clock: source one, divider one.
// - Master clock period equals divider plus one core cycles.
// - Low phase is half period for odd divider, divider/2 when even.
// - High phase is half period for odd divider, divider/2+1 when even.
// - With sync polarity one, master frame sync pin is active low.
// - Slave inverts active-low select on both sync inputs before use.
// - Master drives clock and transmit sync; receive directions are inputs.
// - Slave takes clock and both syncs from outside.
// - Master asserts select before the clock edge that starts transfer.
// - Transfer begins at a rising edge of the master clock in half-delay mode, at a falling edge in no-delay mode.
// - Half-delay mode: select low one full period before first rise.
// - No-delay mode: select low one high phase before first fall.
// - Half-delay mode: select held one low phase after final fall.
// - No-delay mode: select held one full period after final rise.
// - Each new transmit bit launches on a falling clock edge.
// - Receive bits are captured on the rising clock edge.
// - Master floats data output after last bit: at final fall (half-delay), one high phase after final rise (no-delay).
// - Slave drives first bit on select going low, before any clock.
module scs_spi_clock_stop import scs_pkg::*; (
   input  wire logic              core_clk,
   input  wire logic              srst,
   input  wire scs_cfg_s          cfg,
   input  wire logic              tx_word_valid,
   input  wire logic [WORD_W-1:0] tx_word,
   output logic                   tx_word_ready,
   output logic                   rx_word_valid,
   output logic [WORD_W-1:0]      rx_word,
   output logic                   busy,
   output logic                   config_error,
   output scs_dir_s               dir,
   input  wire logic              serial_clock_pin_i,
   output logic                   serial_clock_pin_o,
   output logic                   serial_clock_pin_oe,
   input  wire logic              tx_frame_sync_pin_i,
   output logic                   tx_frame_sync_pin_o,
   output logic                   tx_frame_sync_pin_oe,
   input  wire logic              rx_frame_sync_pin_i,
   output logic                   serial_data_out_pin_o,
   output logic                   serial_data_out_pin_oe,
   input  wire logic              serial_data_in_pin
);

   scs_core_s         r;
   scs_core_s         n;
   scs_gen_s          gen;
   logic              mode_half;
   logic              mode_ok;
   logic              handshake;
   logic [WORD_W-1:0] word_in;
   logic              sclk_s;
   logic              tx_sel;
   logic              rx_sel;
   logic              din_s;
   logic              sl_rise;
   logic              sl_fall;
   logic              sl_sel_on;
   logic              gen_run;

   ////////////////////////////////////////////////////////////////////////
   // Configuration

   assign mode_half = (cfg.clock_stop_select == STOP_HALF_DELAY);
   assign mode_ok   = (mode_half && !cfg.tx_clock_polarity)
                   || (cfg.clock_stop_select == STOP_NO_DELAY
                       && cfg.tx_clock_polarity);

   always_comb begin
      config_error = !mode_ok
                  || !cfg.tx_sync_polarity
                  || !cfg.rx_sync_polarity;
      if (!cfg.master
          && (cfg.rate_gen_source_select != SRC_CPU
              || cfg.rate_gen_divider != DIV_SLAVE)) begin
         config_error = 1'b1;
      end
   end

   always_comb begin
      dir.tx_clock_direction = cfg.master;
      dir.tx_sync_direction  = cfg.master;
      dir.rx_clock_direction = 1'b0;
      dir.rx_sync_direction  = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////
   // Slave-side pin view, sampled at the rate clock

   assign sclk_s = r.sync2[SY_SCLK];
   assign din_s  = r.sync2[SY_DIN];
   assign tx_sel = cfg.tx_sync_polarity ? ~r.sync2[SY_TXFS]
                                        : r.sync2[SY_TXFS];
   assign rx_sel = cfg.rx_sync_polarity ? ~r.sync2[SY_RXFS]
                                        : r.sync2[SY_RXFS];

   assign sl_rise   = gen.rise && sclk_s && !r.sclk_prev;
   assign sl_fall   = gen.rise && !sclk_s && r.sclk_prev;
   assign sl_sel_on = gen.rise && tx_sel && !r.sel_prev;

   assign tx_word_ready = (r.state == ST_IDLE) && !config_error;
   assign handshake     = tx_word_valid && tx_word_ready;
   assign word_in       = handshake ? tx_word : r.tx_sh;

   ////////////////////////////////////////////////////////////////////////
   // Next state

   always_comb begin
      n          = r;
      n.sync1    = {serial_data_in_pin, rx_frame_sync_pin_i,
                    tx_frame_sync_pin_i, serial_clock_pin_i};
      n.sync2    = r.sync1;
      n.rx_valid = 1'b0;
      if (gen.rise) begin
         n.sclk_prev = sclk_s;
         n.sel_prev  = tx_sel;
      end
      case (r.state)
         ST_IDLE: begin
            n.sclk_lvl = cfg.tx_clock_polarity;
            n.fs_act   = 1'b0;
            n.doe      = 1'b0;
            n.pending  = 1'b0;
            n.bits     = '0;
            n.tx_sh    = word_in;
            if (handshake && cfg.master) begin
               n.state  = ST_LEAD;
               n.fs_act = 1'b1;
            end else if (!cfg.master && !config_error && sl_sel_on) begin
               n.state = ST_SLAVE;
               n.dout  = word_in[WORD_W-1];
               n.doe   = 1'b1;
            end
         end
         ST_LEAD: begin
            if (gen.fall) begin
               n.dout = r.tx_sh[WORD_W-1];
               n.doe  = 1'b1;
               if (!mode_half) begin
                  n.sclk_lvl = 1'b0;
                  n.state    = ST_SHIFT;
               end
            end
            if (gen.rise) begin
               n.sclk_lvl = 1'b1;
               n.rx_sh    = {r.rx_sh[WORD_W-2:0], din_s};
               n.bits     = CNT_W'(r.bits + CNT_ONE);
               n.pending  = 1'b1;
               n.state    = ST_SHIFT;
            end
         end
         ST_SHIFT: begin
            if (gen.rise) begin
               n.sclk_lvl = 1'b1;
               n.rx_sh    = {r.rx_sh[WORD_W-2:0], din_s};
               n.bits     = CNT_W'(r.bits + CNT_ONE);
               n.pending  = 1'b1;
               if (r.bits == CNT_LAST) begin
                  n.state    = ST_TRAIL;
                  n.rx_valid = 1'b1;
                  n.rx_word  = {r.rx_sh[WORD_W-2:0], din_s};
               end
            end
            if (gen.fall) begin
               n.sclk_lvl = 1'b0;
               if (r.pending) begin
                  n.tx_sh   = {r.tx_sh[WORD_W-2:0], 1'b0};
                  n.dout    = r.tx_sh[WORD_W-2];
                  n.pending = 1'b0;
               end
            end
         end
         ST_TRAIL: begin
            if (gen.fall) begin
               n.doe      = 1'b0;
               n.sclk_lvl = cfg.tx_clock_polarity;
            end
            if (gen.rise) begin
               n.fs_act = 1'b0;
               n.state  = ST_IDLE;
            end
         end
         ST_SLAVE: begin
            if (sl_rise && rx_sel && r.bits != CNT_FULL) begin
               n.rx_sh   = {r.rx_sh[WORD_W-2:0], din_s};
               n.bits    = CNT_W'(r.bits + CNT_ONE);
               n.pending = 1'b1;
               if (r.bits == CNT_LAST) begin
                  n.rx_valid = 1'b1;
                  n.rx_word  = {r.rx_sh[WORD_W-2:0], din_s};
               end
            end
            if (sl_fall && r.pending && r.bits != CNT_FULL) begin
               n.tx_sh   = {r.tx_sh[WORD_W-2:0], 1'b0};
               n.dout    = r.tx_sh[WORD_W-2];
               n.pending = 1'b0;
            end
            if (gen.rise && !tx_sel) begin
               n.doe   = 1'b0;
               n.state = ST_IDLE;
            end
         end
         default: begin
            n = CORE_RESET;
         end
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         r <= CORE_RESET;
      end else begin
         r <= n;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Rate generator; free running for slave sampling

   assign gen_run = cfg.master ? (n.state != ST_IDLE) : 1'b1;

   scs_rate_gen u_rate_gen (
      .core_clk (core_clk),
      .srst     (srst),
      .run      (gen_run),
      .divider  (cfg.rate_gen_divider),
      .gen      (gen)
   );

   ////////////////////////////////////////////////////////////////////////
   // Outputs

   assign rx_word_valid          = r.rx_valid;
   assign rx_word                = r.rx_word;
   assign busy                   = (r.state != ST_IDLE);
   assign serial_clock_pin_o     = r.sclk_lvl;
   assign serial_clock_pin_oe    = dir.tx_clock_direction;
   assign tx_frame_sync_pin_o    = r.fs_act ^ cfg.tx_sync_polarity;
   assign tx_frame_sync_pin_oe   = dir.tx_sync_direction;
   assign serial_data_out_pin_o  = r.dout;
   assign serial_data_out_pin_oe = r.doe;

   ////////////////////////////////////////////////////////////////////////
   // Checks

   logic [DIV_W:0] lead_cnt;
   logic [DIV_W:0] trail_cnt;
   logic [DIV_W:0] period;

   assign period = (cfg.rate_gen_divider == '0)
                 ? 9'h002 : {1'b0, cfg.rate_gen_divider} + 9'h001;

   always_ff @(posedge core_clk) begin
      if (srst) begin
         lead_cnt  <= '0;
         trail_cnt <= '0;
      end else begin
         lead_cnt  <= (r.state == ST_LEAD)
                    ? (DIV_W+1)'(lead_cnt + 9'h001) : '0;
         trail_cnt <= (r.state == ST_TRAIL)
                    ? (DIV_W+1)'(trail_cnt + 9'h001) : '0;
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (srst);

   a_slave_rate_cfg: assert property (
      !cfg.master && cfg.rate_gen_divider != DIV_SLAVE |->
         !tx_word_ready && r.state != ST_SLAVE ##1 !$rose(busy))
      else $error("slave runs with wrong rate clock");

   a_fs_pin_low: assert property (
      cfg.master && busy |-> !tx_frame_sync_pin_o && tx_frame_sync_pin_oe)
      else $error("master select not active low");

   a_master_dirs: assert property (
      cfg.master |-> serial_clock_pin_oe && tx_frame_sync_pin_oe
         && !dir.rx_clock_direction && !dir.rx_sync_direction)
      else $error("master pin directions wrong");

   a_slave_dirs: assert property (
      !cfg.master |-> !serial_clock_pin_oe && !tx_frame_sync_pin_oe)
      else $error("slave pin directions wrong");

   a_fs_leads_clk: assert property (
      r.state == ST_IDLE && n.state == ST_LEAD |=>
         tx_frame_sync_pin_o == 1'b0
         && serial_clock_pin_o == cfg.tx_clock_polarity)
      else $error("select not ahead of clock");

   a_lead_half: assert property (
      mode_half && r.state == ST_LEAD && n.state == ST_SHIFT |->
         lead_cnt == period - 9'h001 ##1 serial_clock_pin_o)
      else $error("half delay lead time wrong");

   a_lead_none: assert property (
      !mode_half && r.state == ST_LEAD && n.state == ST_SHIFT |->
         lead_cnt == {1'b0, scs_phase_len(cfg.rate_gen_divider, 1'b1)}
            - 9'h001 ##1 !serial_clock_pin_o)
      else $error("no delay lead time wrong");

   a_tail_hold: assert property (
      r.state == ST_TRAIL && gen.rise |->
         trail_cnt == period - 9'h001 ##1 tx_frame_sync_pin_o)
      else $error("select tail hold wrong");

   a_launch_fall: assert property (
      (r.state == ST_LEAD || r.state == ST_SHIFT) && !gen.fall |=>
         $stable(serial_data_out_pin_o))
      else $error("data launched off falling edge");

   a_capture_rise: assert property (
      cfg.master && !gen.rise |=> $stable(r.rx_sh))
      else $error("data captured off rising edge");

   a_master_hiz: assert property (
      r.state == ST_TRAIL && gen.fall |=>
         !serial_data_out_pin_oe [*2])
      else $error("master data not released");

   a_slave_release: assert property (
      r.state == ST_SLAVE && gen.rise && !tx_sel |=>
         !serial_data_out_pin_oe && !busy)
      else $error("slave data not released");

   a_slave_first: assert property (
      r.state == ST_IDLE && n.state == ST_SLAVE |=>
         serial_data_out_pin_oe
         && serial_data_out_pin_o == $past(word_in[WORD_W-1]))
      else $error("slave first bit not driven");

   a_clk_idle: assert property (
      cfg.master && !busy && $past(!busy)
         && $stable(cfg.tx_clock_polarity) |->
         serial_clock_pin_o == cfg.tx_clock_polarity)
      else $error("clock not idle between words");

   c_master_half: cover property (
      cfg.master && mode_half && rx_word_valid);
   c_master_none: cover property (
      cfg.master && !mode_half && rx_word_valid);
   c_slave_word: cover property (!cfg.master && rx_word_valid);
   c_cfg_error: cover property (config_error && tx_word_valid);

endmodule : scs_spi_clock_stop

// ---- design/scs_pkg.sv ----
package scs_pkg;

   localparam int WORD_W  = 16;
   localparam int CNT_W   = 5;
   localparam int DIV_W   = 8;
   localparam int SYNC_W  = 4;
   localparam int SY_SCLK = 0;
   localparam int SY_TXFS = 1;
   localparam int SY_RXFS = 2;
   localparam int SY_DIN  = 3;

   localparam logic [1:0]       STOP_NO_DELAY     = 2'h2;
   localparam logic [1:0]       STOP_HALF_DELAY   = 2'h3;
   localparam logic             SRC_CPU           = 1'h1;
   localparam logic [DIV_W-1:0] DIV_SLAVE         = 8'h01;
   localparam logic [DIV_W-1:0] DIV_ONE           = 8'h01;
   localparam logic [CNT_W-1:0] CNT_ONE           = 5'h01;
   localparam logic [CNT_W-1:0] CNT_LAST          = 5'h0F;
   localparam logic [CNT_W-1:0] CNT_FULL          = 5'h10;

   typedef enum logic [4:0] {
      ST_IDLE  = 5'h01,
      ST_LEAD  = 5'h02,
      ST_SHIFT = 5'h04,
      ST_TRAIL = 5'h08,
      ST_SLAVE = 5'h10
   } scs_state_e;

   typedef struct packed {
      logic             master;
      logic [1:0]       clock_stop_select;
      logic             tx_clock_polarity;
      logic             rate_gen_source_select;
      logic [DIV_W-1:0] rate_gen_divider;
      logic             tx_sync_polarity;
      logic             rx_sync_polarity;
   } scs_cfg_s;

   typedef struct packed {
      logic tx_clock_direction;
      logic rx_clock_direction;
      logic tx_sync_direction;
      logic rx_sync_direction;
   } scs_dir_s;

   typedef struct packed {
      logic             level;
      logic             rise;
      logic             fall;
      logic [DIV_W-1:0] cnt;
   } scs_gen_s;

   typedef struct packed {
      scs_state_e        state;
      logic [SYNC_W-1:0] sync1;
      logic [SYNC_W-1:0] sync2;
      logic              sclk_prev;
      logic              sel_prev;
      logic [WORD_W-1:0] tx_sh;
      logic [WORD_W-1:0] rx_sh;
      logic [CNT_W-1:0]  bits;
      logic              pending;
      logic              sclk_lvl;
      logic              fs_act;
      logic              dout;
      logic              doe;
      logic              rx_valid;
      logic [WORD_W-1:0] rx_word;
   } scs_core_s;

   localparam scs_gen_s GEN_IDLE =
      '{level: 1'b1, rise: 1'b0, fall: 1'b0, cnt: '0};
   localparam scs_core_s CORE_RESET =
      '{state: ST_IDLE, sync1: '1, sync2: '1, sel_prev: 1'b1, default: '0};

   // Phase length in core cycles; a zero divider acts as one
   function automatic logic [DIV_W-1:0] scs_phase_len(
      input logic [DIV_W-1:0] div,
      input logic             high
   );
      logic [DIV_W:0] d;
      d = (div == '0) ? {1'b0, DIV_ONE} : {1'b0, div};
      if (d[0]) begin
         scs_phase_len = DIV_W'((d + 9'h001) >> 1);
      end else begin
         scs_phase_len = DIV_W'((d >> 1) + {8'h00, high});
      end
   endfunction : scs_phase_len

endpackage : scs_pkg

// ---- design/scs_rate_gen.sv ----
`timescale 1ns/1ps
module scs_rate_gen import scs_pkg::*; (
   input  wire logic             core_clk,
   input  wire logic             srst,
   input  wire logic             run,
   input  wire logic [DIV_W-1:0] divider,
   output scs_gen_s              gen
);

   scs_gen_s         r;
   scs_gen_s         next_r;
   logic [DIV_W-1:0] len;

   always_comb begin
      len         = scs_phase_len(divider, r.level);
      next_r      = r;
      next_r.rise = 1'b0;
      next_r.fall = 1'b0;
      if (!run) begin
         next_r = GEN_IDLE;
      end else if (r.cnt == DIV_W'(len - DIV_ONE)) begin
         next_r.level = ~r.level;
         next_r.rise  = ~r.level;
         next_r.fall  = r.level;
         next_r.cnt   = '0;
      end else begin
         next_r.cnt = DIV_W'(r.cnt + DIV_ONE);
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         r <= GEN_IDLE;
      end else begin
         r <= next_r;
      end
   end

   assign gen = r;

   ////////////////////////////////////////////////////////////////////////
   logic [DIV_W:0] per_cnt;
   logic [DIV_W:0] ph_cnt;
   logic           seen_rise;
   logic           seen_edge;

   always_ff @(posedge core_clk) begin
      if (srst || !run) begin
         per_cnt   <= '0;
         ph_cnt    <= '0;
         seen_rise <= 1'b0;
         seen_edge <= 1'b0;
      end else begin
         per_cnt   <= r.rise ? 9'h001 : (DIV_W+1)'(per_cnt + 9'h001);
         ph_cnt    <= (r.rise || r.fall) ? 9'h001
                                         : (DIV_W+1)'(ph_cnt + 9'h001);
         seen_rise <= seen_rise | r.rise;
         seen_edge <= seen_edge | r.rise | r.fall;
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (srst);

   a_period_len: assert property (
      r.rise && seen_rise && $stable(divider) |->
         per_cnt == ((divider == '0) ? 9'h002 : {1'b0, divider} + 9'h001))
      else $error("rate clock period wrong");

   a_low_phase: assert property (
      r.rise && seen_edge && $stable(divider) |->
         ph_cnt == {1'b0, scs_phase_len(divider, 1'b0)})
      else $error("rate clock low phase wrong");

   a_high_phase: assert property (
      r.fall && seen_edge && $stable(divider) |->
         ph_cnt == {1'b0, scs_phase_len(divider, 1'b1)})
      else $error("rate clock high phase wrong");

endmodule : scs_rate_gen

// ---- verification/scs_peer.sv ----
`timescale 1ns/1ps
module scs_peer import scs_pkg::*; (
   input  wire logic              core_clk,
   input  wire logic              peer_master,
   input  wire logic              sclk_in,
   input  wire logic              sel_n_in,
   input  wire logic              sdi,
   input  wire logic [WORD_W-1:0] word_out,
   output logic                   sclk_out,
   output logic                   sel_n_out,
   output logic                   sdo,
   output logic [WORD_W-1:0]      word_in,
   output logic                   first_bit
);
   logic [WORD_W-1:0] sh;
   logic              tog;
   logic              m_sdo;

   initial begin
      sclk_out  = 1'b0;
      sel_n_out = 1'b1;
      m_sdo     = 1'b0;
      tog       = 1'b0;
      word_in   = '0;
      first_bit = 1'b0;
   end

   // Released line toggles so stale data never looks valid
   assign sdo = peer_master ? m_sdo : (sel_n_in ? tog : sh[WORD_W-1]);

   always @(posedge core_clk) begin
      tog <= ~tog;
      if (sel_n_in) sh <= word_out;
   end

   // Slave side: capture, then next bit right at the pin rise
   always @(posedge sclk_in) begin
      if (!peer_master && !sel_n_in) begin
         word_in = {word_in[WORD_W-2:0], sdi};
         sh      = sh << 1;
      end
   end

   // Master side: wide phases so the sampler never starves
   task automatic frame(input logic pol, input logic [WORD_W-1:0] w);
      int i;
      sclk_out <= pol;
      @(posedge core_clk);
      sel_n_out <= 1'b0;
      repeat (10) @(posedge core_clk);
      first_bit <= sdi;
      for (i = WORD_W - 1; i >= 0; i--) begin
         m_sdo <= w[i];
         repeat (8) @(posedge core_clk);
         sclk_out <= ~pol;
         if (!pol) word_in <= {word_in[WORD_W-2:0], sdi};
         repeat (8) @(posedge core_clk);
         sclk_out <= pol;
         if (pol) word_in <= {word_in[WORD_W-2:0], sdi};
         repeat (8) @(posedge core_clk);
      end
      sel_n_out <= 1'b1;
      @(posedge core_clk);
   endtask : frame
endmodule : scs_peer

// ---- verification/test_serial_port_spi_clock_stop_mode.sv ----
`timescale 1ns/1ps
module test_serial_port_spi_clock_stop_mode import scs_pkg::*;;
   localparam int LIMIT = 20000;
   logic              core_clk, srst, tx_word_valid, tx_word_ready;
   logic              rx_word_valid, busy, config_error, peer_m;
   logic              sclk_o, sclk_oe, fs_o, fs_oe, dout, doe;
   logic              peer_sclk, peer_sel, peer_sdo, peer_first;
   logic              fs_q, sck_q, oe_q, do_q;
   logic [WORD_W-1:0] tx_word, rx_word, peer_in, peer_word, got;
   logic [31:0]       seed;
   scs_cfg_s          cfg;
   scs_cfg_s          bad [5];
   scs_dir_s          dir;
   wire               sclk_w, fs_w, dout_w;
   int                n_errors, total_checks, cyc, t_dn, t_up, t_off, nb, k;
   int                qr[$];
   int                qf[$];

   assign sclk_w = sclk_oe ? sclk_o : peer_sclk;
   assign fs_w   = fs_oe ? fs_o : peer_sel;
   assign dout_w = doe ? dout : ~dout;

   scs_spi_clock_stop i_dut (.core_clk(core_clk), .srst(srst), .cfg(cfg),
      .tx_word_valid(tx_word_valid), .tx_word(tx_word),
      .tx_word_ready(tx_word_ready), .rx_word_valid(rx_word_valid),
      .rx_word(rx_word), .busy(busy), .config_error(config_error),
      .dir(dir), .serial_clock_pin_i(sclk_w),
      .serial_clock_pin_o(sclk_o), .serial_clock_pin_oe(sclk_oe),
      .tx_frame_sync_pin_i(fs_w), .tx_frame_sync_pin_o(fs_o),
      .tx_frame_sync_pin_oe(fs_oe), .rx_frame_sync_pin_i(fs_w),
      .serial_data_out_pin_o(dout), .serial_data_out_pin_oe(doe),
      .serial_data_in_pin(peer_sdo));

   scs_peer i_peer (.core_clk(core_clk), .peer_master(peer_m),
      .sclk_in(sclk_w), .sel_n_in(fs_w), .sdi(dout_w),
      .word_out(peer_word), .sclk_out(peer_sclk), .sel_n_out(peer_sel),
      .sdo(peer_sdo), .word_in(peer_in), .first_bit(peer_first));

   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end

   ////////////////////////////////////////////////////////////////////////
   // Edge log of the pins, sampled once per cycle
   always @(posedge core_clk) begin
      cyc++;
      if (rx_word_valid === 1'b1) got = rx_word;
      if (!fs_w && fs_q) begin
         t_dn = cyc;
         qr.delete();
         qf.delete();
      end
      if (fs_w && !fs_q) t_up = cyc;
      if (!fs_w && sclk_w && !sck_q) qr.push_back(cyc);
      if (!fs_w && !sclk_w && sck_q) qf.push_back(cyc);
      if (!doe && oe_q) t_off = cyc;
      if (sclk_oe && doe && oe_q && dout !== do_q && !(sck_q && !sclk_w))
         nb++;
      fs_q  = fs_w;
      sck_q = sclk_w;
      oe_q  = doe;
      do_q  = dout;
   end

   initial begin
      wait (cyc == LIMIT);
      n_errors++;
      stop_test();
   end

   ////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd

   function automatic int ph(input int d, input int hi);
      if (d % 2) return (d + 1) / 2;
      return d / 2 + hi;
   endfunction : ph

   function automatic scs_cfg_s mk(logic m, logic [1:0] s, logic p, logic c,
                                   logic [DIV_W-1:0] d);
      return '{master: m, clock_stop_select: s, tx_clock_polarity: p,
               rate_gen_source_select: c, rate_gen_divider: d,
               tx_sync_polarity: 1'b1, rx_sync_polarity: 1'b1};
   endfunction : mk

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask : check

   task automatic send(input logic [WORD_W-1:0] w);
      int n;
      n = 0;
      @(negedge core_clk);
      tx_word       = w;
      tx_word_valid = 1'b1;
      while (tx_word_ready !== 1'b1 && n < 100) begin
         @(negedge core_clk);
         n++;
      end
      @(negedge core_clk);
      tx_word_valid = 1'b0;
   endtask : send

   task automatic master_word(input logic a, input int d);
      logic [WORD_W-1:0] w;
      int                p, hi, lo, i, n;
      w         = WORD_W'(rnd());
      peer_word = WORD_W'(rnd());
      p  = d + 1;
      hi = ph(d, 1);
      lo = ph(d, 0);
      nb = 0;
      n  = 0;
      @(negedge core_clk);
      cfg = mk(1'b1, a ? STOP_HALF_DELAY : STOP_NO_DELAY, !a, 1'b0,
               DIV_W'(d));
      @(negedge core_clk);
      check({28'h0000000, dir}, 32'h0000000A);
      check(fs_o, 1'b1);
      send(w);
      while (busy !== 1'b0 && n < 2000) begin
         @(negedge core_clk);
         n++;
      end
      @(negedge core_clk);
      check(got, peer_word);
      check(peer_in, w);
      check(qr.size(), WORD_W);
      check(qf.size(), WORD_W);
      check(sclk_o, !a);
      check(nb, 0);
      for (i = 1; i < WORD_W; i++) begin
         check(qr[i] - qr[i-1], p);
         check(a ? qf[i-1] - qr[i-1] : qf[i] - qr[i-1], hi);
         check(a ? qr[i] - qf[i-1] : qr[i-1] - qf[i-1], lo);
      end
      if (a) begin
         check(qr[0] - t_dn, p);
         check(t_up - qf[WORD_W-1], lo);
         check(t_off, qf[WORD_W-1]);
      end else begin
         check(qf[0] - t_dn, hi);
         check(t_up - qr[WORD_W-1], p);
         check(t_off, qr[WORD_W-1] + hi);
      end
   endtask : master_word

   task automatic slave_word(input logic pol);
      logic [WORD_W-1:0] w, pw;
      w  = WORD_W'(rnd());
      pw = WORD_W'(rnd());
      @(negedge core_clk);
      peer_m = 1'b1;
      cfg    = mk(1'b0, pol ? STOP_NO_DELAY : STOP_HALF_DELAY, pol, SRC_CPU,
                  DIV_SLAVE);
      repeat (4) @(negedge core_clk);
      check({28'h0000000, dir}, 32'h00000000);
      send(w);
      i_peer.frame(pol, pw);
      repeat (8) @(negedge core_clk);
      check(got, pw);
      check(peer_in, w);
      check(peer_first, w[WORD_W-1]);
      check(doe, 1'b0);
   endtask : slave_word

   task automatic stop_test();
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : stop_test

   ////////////////////////////////////////////////////////////////////////
   initial begin
      seed          = 32'h00015E1D;
      srst          = 1'b1;
      peer_m        = 1'b0;
      tx_word_valid = 1'b0;
      tx_word       = '0;
      peer_word     = '0;
      cfg           = mk(1'b1, STOP_HALF_DELAY, 1'b0, 1'b0, 8'h03);
      bad[0] = mk(1'b1, STOP_HALF_DELAY, 1'b1, 1'b0, 8'h03);
      bad[1] = mk(1'b1, STOP_NO_DELAY, 1'b0, 1'b0, 8'h03);
      bad[2] = mk(1'b1, 2'h0, 1'b0, 1'b0, 8'h03);
      bad[3] = mk(1'b0, STOP_HALF_DELAY, 1'b0, SRC_CPU, 8'h02);
      bad[4] = mk(1'b0, STOP_HALF_DELAY, 1'b0, 1'b0, DIV_SLAVE);
      repeat (2) @(negedge core_clk);
      srst = 1'b0;
      // Refused settings with a request held up
      foreach (bad[i]) begin
         @(negedge core_clk);
         cfg           = bad[i];
         tx_word_valid = 1'b1;
         @(negedge core_clk);
         check(config_error, 1'b1);
         check(tx_word_ready, 1'b0);
         check(busy, 1'b0);
      end
      tx_word_valid = 1'b0;
      for (k = 0; k < 10; k++)
         master_word(k[0], k < 2 ? 3 + k : 3 + int'(rnd() % 7));
      for (k = 0; k < 4; k++)
         slave_word(k[0]);
      stop_test();
   end
endmodule : test_serial_port_spi_clock_stop_mode
